// ===== cecrx_consts.svh
// Register offsets, field positions, reset values and timing counts of the CEC receiver
`ifndef CECRX_CONSTS_SVH
`define CECRX_CONSTS_SVH
// ==========================================================
// Register byte offsets
`define CECRX_ADR_CTRL  8'h00
`define CECRX_ADR_CFG   8'h04
`define CECRX_ADR_SBIT  8'h08
`define CECRX_ADR_WAVE  8'h0c
`define CECRX_ADR_LADDR 8'h10
`define CECRX_ADR_STAT  8'h14
`define CECRX_ADR_RBUF  8'h18
// ==========================================================
// Control bits
`define CECRX_CTRL_EN     0
`define CECRX_CTRL_ACKDIS 1
`define CECRX_CTRL_OTH    2
`define CECRX_CTRL_SUSP   3
`define CECRX_CTRL_WAVEN  4
// ==========================================================
// Fields of rx_control_one
`define CECRX_LNC_LSB  0
`define CECRX_HNC_LSB  4
`define CECRX_MIN_LSB  8
`define CECRX_MAX_LSB  12
`define CECRX_DAT_LSB  16
`define CECRX_TOUT_LSB 24
// ==========================================================
// Status flag positions
`define CECRX_F_START 0
`define CECRX_F_END   1
`define CECRX_F_MIN   2
`define CECRX_F_MAX   3
`define CECRX_F_OVR   4
`define CECRX_F_WAV   5
// ==========================================================
// Reset values
`define CECRX_CTRL_RST 32'h0000_0000
`define CECRX_CFG_RST  32'hc800_0023
`define CECRX_SBIT_RST 32'h9a8d_8073
`define CECRX_WAVE_RST 32'h382b_1a0d
// ==========================================================
// Timing in sampling-clock periods
`define CECRX_FS_HZ         32768
`define CECRX_MAX_NOM       8'h5a
`define CECRX_MIN_NOM       8'h43
`define CECRX_DAT_NOM       8'h22
`define CECRX_ACK_LOW_US    1526
`define CECRX_MINERR_LOW_US 3630
`define CECRX_ACK_TICKS ((`CECRX_ACK_LOW_US * `CECRX_FS_HZ + 500000) / 1000000)
`define CECRX_MINERR_TICKS ((`CECRX_MINERR_LOW_US * `CECRX_FS_HZ + 500000) / 1000000)
`endif

// ===== cecrx_pkg.sv
// Types shared by the CEC receiver modules
package cecrx_pkg;
  // ==========================================================
  // Receiver states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SLOW  = 5'h02,
    ST_SHIGH = 5'h04,
    ST_BLOW  = 5'h08,
    ST_BHIGH = 5'h10
  } cecrx_state_e;
  // ==========================================================
  // Wishbone carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cecrx_wb_req_s;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } cecrx_wb_rsp_s;
  // ==========================================================
  // Main module state
  typedef struct packed {
    cecrx_state_e st;
    logic [7:0]   cnt;
    logic [3:0]   bit_idx;
    logic [7:0]   shreg;
    logic         eom;
    logic         hdr;
    logic         amatch;
    logic         wav_done;
    logic [2:0]   pend;
    logic         susp_act;
    logic [6:0]   drv_cnt;
    logic         drv;
    logic [31:0]  ctrl;
    logic [31:0]  cfg;
    logic [31:0]  sbit;
    logic [31:0]  wave;
    logic [15:0]  laddr;
    logic [5:0]   flags;
    logic [9:0]   rbuf;
    logic         rfull;
    logic         ack;
    logic [31:0]  rdat;
  } cecrx_main_s;
endpackage

// ===== cecrx_sync2.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module cecrx_sync2 #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cecrx_sync_s;
  cecrx_sync_s q;
  cecrx_sync_s d;
  always_comb begin
    d.s1 = d_i;
    d.s2 = q.s1;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign q_o = q.s2;
endmodule

// ===== cecrx_nfilt.sv
// Sampling-clock edge detect and line noise filter
`timescale 1ns/100ps
module cecrx_nfilt (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       fs_i,
  input  wire logic       line_i,
  input  wire logic [2:0] lnc_i,
  input  wire logic [1:0] hnc_i,
  output logic            smp_o,
  output logic            level_o,
  output logic            fall_o,
  output logic            rise_o
);
  typedef struct packed {
    logic       fs_q;
    logic       lvl;
    logic [2:0] cnt;
    logic       smp;
    logic       fall;
    logic       rise;
  } cecrx_filt_s;
  cecrx_filt_s q;
  cecrx_filt_s d;
  logic [2:0]  need;
  always_comb begin
    d = q;
    d.smp = 1'b0;
    d.fall = 1'b0;
    d.rise = 1'b0;
    d.fs_q = fs_i;
    // Field value n means n+1 consecutive samples
    need = q.lvl ? lnc_i : {1'b0, hnc_i};
    if (fs_i && !q.fs_q) begin
      d.smp = 1'b1;
      if (line_i != q.lvl) begin
        if (q.cnt == need) begin
          d.lvl = line_i;
          d.cnt = 3'h0;
          d.fall = q.lvl;
          d.rise = ~q.lvl;
        end else begin
          d.cnt = q.cnt + 3'h1;
        end
      end else begin
        d.cnt = 3'h0;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{lvl: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end
  assign smp_o = q.smp;
  assign level_o = q.lvl;
  assign fall_o = q.fall;
  assign rise_o = q.rise;
endmodule

// ===== cecrx_timing_checker.sv
// CEC receiver: bit timing checks, ACK response, error suspension, Wishbone registers
//
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`include "cecrx_consts.svh"
module cecrx_timing_checker (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     fs_i,
  input  wire logic                     cec_i,
  input  wire logic                     tx_active_i,
  input  wire cecrx_pkg::cecrx_wb_req_s wb_req_i,
  output cecrx_pkg::cecrx_wb_rsp_s      wb_rsp_o,
  output logic                          cec_o,
  output logic                          cec_oe_o
);
  import cecrx_pkg::*;
  localparam cecrx_main_s RST_S = '{
    st:    ST_IDLE,
    ctrl:  `CECRX_CTRL_RST,
    cfg:   `CECRX_CFG_RST,
    sbit:  `CECRX_SBIT_RST,
    wave:  `CECRX_WAVE_RST,
    default: '0
  };
  cecrx_main_s q;
  cecrx_main_s d;
  logic        fs_s;
  logic        cec_s;
  logic        smp;
  logic        lvl;
  logic        fall;
  logic        rise;
  logic        req;
  logic        wr;
  logic        en;
  logic        susp_en;
  logic        waven;
  logic        ack_ok;
  logic [7:0]  tnow;
  logic [7:0]  minlim;
  logic [7:0]  maxlim;
  logic [7:0]  dpt;
  logic [3:0]  dest;
  logic [5:0]  set;
  logic [5:0]  clr;
  logic [2:0]  serr;
  logic [31:0] wtmp;
  logic        ev_start;
  logic        ev_min;
  logic        ev_ackdrv;
  logic        ev_store;
  logic        ev_maxerr;
  logic        ev_tout;

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] w,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = w[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Pin capture and filtering
  cecrx_sync2 #(
    .W (2)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({fs_i, cec_i}),
    .q_o   ({fs_s, cec_s})
  );
  cecrx_nfilt u_filt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .fs_i    (fs_s),
    .line_i  (cec_s),
    .lnc_i   (q.cfg[`CECRX_LNC_LSB +: 3]),
    .hnc_i   (q.cfg[`CECRX_HNC_LSB +: 2]),
    .smp_o   (smp),
    .level_o (lvl),
    .fall_o  (fall),
    .rise_o  (rise)
  );

  // ==========================================================
  // Timing windows
  assign tnow = (q.cnt == 8'hff) ? q.cnt : q.cnt + 8'h01;
  assign minlim = `CECRX_MIN_NOM + {{5{q.cfg[`CECRX_MIN_LSB+2]}}, q.cfg[`CECRX_MIN_LSB +: 3]};
  assign maxlim = `CECRX_MAX_NOM + {{5{q.cfg[`CECRX_MAX_LSB+2]}}, q.cfg[`CECRX_MAX_LSB +: 3]};
  assign dpt = `CECRX_DAT_NOM + {{4{q.cfg[`CECRX_DAT_LSB+2]}}, q.cfg[`CECRX_DAT_LSB +: 3], 1'b0};
  assign en = q.ctrl[`CECRX_CTRL_EN] & ~tx_active_i;
  assign susp_en = q.ctrl[`CECRX_CTRL_SUSP];
  assign waven = q.ctrl[`CECRX_CTRL_WAVEN];
  // Header ACK ignores ACK-disable; data ACK honours it
  assign ack_ok = q.amatch & (q.hdr | ~q.ctrl[`CECRX_CTRL_ACKDIS]);
  assign req = wb_req_i.cyc & wb_req_i.stb;
  // Writes land on the edge where the master sees ack
  assign wr = req & q.ack & wb_req_i.we;

  // ==========================================================
  // Next-state logic
  always_comb begin
    d = q;
    set = 6'h00;
    clr = 6'h00;
    serr = 3'h0;
    dest = 4'h0;
    wtmp = 32'h0000_0000;
    ev_start = 1'b0;
    ev_min = 1'b0;
    ev_ackdrv = 1'b0;
    ev_store = 1'b0;
    ev_maxerr = 1'b0;
    ev_tout = 1'b0;
    d.ack = req & ~q.ack;
    if (req && !q.ack) begin
      case (wb_req_i.adr)
        `CECRX_ADR_CTRL:  d.rdat = q.ctrl;
        `CECRX_ADR_CFG:   d.rdat = q.cfg;
        `CECRX_ADR_SBIT:  d.rdat = q.sbit;
        `CECRX_ADR_WAVE:  d.rdat = q.wave;
        `CECRX_ADR_LADDR: d.rdat = {16'h0000, q.laddr};
        `CECRX_ADR_STAT:  d.rdat = {21'h00_0000, tx_active_i, q.ctrl[`CECRX_CTRL_EN],
                                    q.st != ST_IDLE, 2'h0, q.flags};
        `CECRX_ADR_RBUF:  d.rdat = {21'h00_0000, q.rfull, q.rbuf};
        default:          d.rdat = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (wb_req_i.adr)
        `CECRX_ADR_CTRL:  d.ctrl = wmerge(q.ctrl, wb_req_i.dat, wb_req_i.sel) & 32'h0000_001f;
        `CECRX_ADR_CFG:   d.cfg = wmerge(q.cfg, wb_req_i.dat, wb_req_i.sel) & 32'hff07_7737;
        `CECRX_ADR_SBIT:  d.sbit = wmerge(q.sbit, wb_req_i.dat, wb_req_i.sel);
        `CECRX_ADR_WAVE:  d.wave = wmerge(q.wave, wb_req_i.dat, wb_req_i.sel);
        `CECRX_ADR_LADDR: begin
          wtmp = wmerge({16'h0000, q.laddr}, wb_req_i.dat, wb_req_i.sel);
          d.laddr = wtmp[15:0];
        end
        `CECRX_ADR_STAT:  clr = wb_req_i.sel[0] ? wb_req_i.dat[5:0] : 6'h00;
        default:          d.rdat = q.rdat;
      endcase
    end
    // Reading the buffer frees it; a store in the same cycle still finds it full and counts as an overrun
    if (req && q.ack && !wb_req_i.we && wb_req_i.adr == `CECRX_ADR_RBUF) begin
      d.rfull = 1'b0;
    end
    if (!en) begin
      // Disabling also stops a minimum-error low drive
      d.st = ST_IDLE;
      d.pend = 3'h0;
      d.susp_act = 1'b0;
      d.drv_cnt = 7'h00;
    end else if (smp) begin
      if (q.drv_cnt != 7'h00) begin
        d.drv_cnt = q.drv_cnt - 7'h01;
      end
      d.cnt = tnow;
      if ((q.st == ST_BLOW || q.st == ST_BHIGH) && tnow == dpt) begin
        if (q.bit_idx < 4'h8) begin
          d.shreg = {q.shreg[6:0], lvl};
        end
        if (q.bit_idx == 4'h7 && q.hdr) begin
          dest = {q.shreg[2:0], lvl};
          d.amatch = q.laddr[dest];
          // Foreign traffic is dropped unless broadcast or other-address mode
          if (!q.laddr[dest] && dest != 4'hf && !q.ctrl[`CECRX_CTRL_OTH]) begin
            d.st = ST_IDLE;
          end
        end
        if (q.bit_idx == 4'h8) begin
          d.eom = lvl;
        end
        if (q.bit_idx == 4'h9) begin
          ev_store = 1'b1;
          if (q.rfull) begin
            serr[1] = 1'b1;
          end else begin
            d.rbuf = {lvl, q.eom, q.shreg};
            d.rfull = 1'b1;
            set[`CECRX_F_END] = 1'b1;
          end
          set[5:3] = q.pend;
          d.pend = 3'h0;
          d.susp_act = 1'b0;
          d.hdr = 1'b0;
          if (q.eom) begin
            d.st = ST_IDLE;
          end
        end
      end
      unique case (q.st)
        ST_IDLE: begin
          if (fall && q.drv_cnt == 7'h00) begin
            d.st = ST_SLOW;
            d.cnt = 8'h00;
          end
        end
        ST_SLOW: begin
          if (rise) begin
            d.st = (tnow >= q.sbit[7:0] && tnow <= q.sbit[15:8]) ? ST_SHIGH : ST_IDLE;
          end else if (tnow > q.sbit[15:8]) begin
            d.st = ST_IDLE;
          end
        end
        ST_SHIGH: begin
          if (fall) begin
            d.cnt = 8'h00;
            if (tnow >= q.sbit[23:16] && tnow <= q.sbit[31:24]) begin
              ev_start = 1'b1;
              set[`CECRX_F_START] = 1'b1;
              d.st = ST_BLOW;
              d.bit_idx = 4'h0;
              d.hdr = 1'b1;
              d.wav_done = 1'b0;
            end else begin
              // Treat the bad fall as the possible start of a fresh start bit
              d.st = ST_SLOW;
            end
          end else if (tnow > q.sbit[31:24]) begin
            d.st = ST_IDLE;
          end
        end
        ST_BLOW: begin
          if (rise) begin
            if (waven && !q.wav_done &&
                (tnow < q.wave[7:0] || (tnow > q.wave[15:8] && tnow < q.wave[23:16]))) begin
              serr[2] = 1'b1;
            end
            d.st = ST_BHIGH;
          end else if (q.bit_idx == 4'h0 && !q.hdr && tnow > q.wave[31:24]) begin
            // Long low where a block should begin: a new start bit
            set[`CECRX_F_MAX] = 1'b1;
            set[5:3] = set[5:3] | q.pend;
            d.pend = 3'h0;
            d.susp_act = 1'b0;
            d.st = ST_SLOW;
          end else if (waven && !q.wav_done && tnow > q.wave[31:24]) begin
            serr[2] = 1'b1;
            d.wav_done = 1'b1;
          end
        end
        ST_BHIGH: begin
          if (fall) begin
            d.cnt = 8'h00;
            if (tnow < minlim) begin
              ev_min = 1'b1;
              set[`CECRX_F_MIN] = 1'b1;
              set[5:3] = q.pend;
              d.pend = 3'h0;
              d.susp_act = 1'b0;
              // The filtered fall already carries the low-level filter delay
              d.drv_cnt = 7'(`CECRX_MINERR_TICKS);
              d.st = ST_IDLE;
            end else begin
              d.st = ST_BLOW;
              d.wav_done = 1'b0;
              d.bit_idx = (q.bit_idx == 4'h9) ? 4'h0 : q.bit_idx + 4'h1;
              // Suspended errors turn the ACK answer round
              if (q.bit_idx == 4'h8 && (ack_ok ^ q.susp_act)) begin
                ev_ackdrv = 1'b1;
                d.drv_cnt = 7'(`CECRX_ACK_TICKS);
              end
            end
          end else if (tnow > maxlim && !q.pend[0]) begin
            ev_maxerr = 1'b1;
            serr[0] = 1'b1;
          end
        end
        default: d.st = ST_IDLE;
      endcase
      if (serr != 3'h0) begin
        if (susp_en) begin
          d.pend = d.pend | serr;
          d.susp_act = 1'b1;
        end else begin
          set[5:3] = set[5:3] | serr;
          d.st = ST_IDLE;
        end
      end
      if (susp_en && q.susp_act && (q.st == ST_BLOW || q.st == ST_BHIGH) &&
          tnow >= q.cfg[`CECRX_TOUT_LSB +: 8]) begin
        ev_tout = 1'b1;
        d.st = ST_IDLE;
      end
    end
    // Whatever is still held is reported once reception ends other than by disabling
    if (d.st == ST_IDLE && d.pend != 3'h0) begin
      set[5:3] = set[5:3] | d.pend;
      d.pend = 3'h0;
      d.susp_act = 1'b0;
    end
    d.flags = (q.flags & ~clr) | set;
    d.drv = (d.drv_cnt != 7'h00);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= RST_S;
    end else begin
      q <= d;
    end
  end

  assign wb_rsp_o = {q.ack, q.rdat};
  assign cec_oe_o = q.drv;
  assign cec_o = 1'b0;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_wb_ack_pulse: assert property (req && !q.ack |=> q.ack ##1 !q.ack)
    else $error("bus ack not a one-cycle answer");
  a_start_valid: assert property (ev_start |=> q.flags[`CECRX_F_START] && q.st == ST_BLOW)
    else $error("valid start bit not taken");
  a_min_drive: assert property (ev_min |=> q.drv && q.flags[`CECRX_F_MIN] &&
                                q.drv_cnt == 7'(`CECRX_MINERR_TICKS))
    else $error("minimum error low drive wrong");
  a_ack_drive: assert property (ev_ackdrv |=> q.drv && q.drv_cnt == 7'(`CECRX_ACK_TICKS))
    else $error("ACK low drive wrong");
  a_store_buf: assert property (ev_store && !q.rfull |=>
                                q.rfull && q.flags[`CECRX_F_END] && q.rbuf[7:0] == q.shreg)
    else $error("received byte not stored");
  a_suspend_hold: assert property (ev_maxerr && susp_en && !q.flags[`CECRX_F_MAX] |=>
                                   !q.flags[`CECRX_F_MAX] && q.pend[0])
    else $error("suspended error reported early");
  a_abort_idle: assert property (ev_maxerr && !susp_en |=>
                                 q.st == ST_IDLE && q.flags[`CECRX_F_MAX])
    else $error("maximum error did not abort");
  a_disable_stop: assert property (!en |=> q.st == ST_IDLE && !cec_oe_o)
    else $error("disabled receiver still active");
  a_short_cycle: assert property (smp && en && q.st == ST_BHIGH && fall && tnow < minlim |=>
                                  q.flags[`CECRX_F_MIN])
    else $error("short bit cycle not flagged");
  a_timeout_end: assert property (ev_tout |=> q.st == ST_IDLE && !q.susp_act &&
                                  q.pend == 3'h0)
    else $error("timeout did not end reception");
endmodule

// ===== cecrx_initiator.sv
// Behavioural CEC initiator that drives start bits and data blocks on the shared line
`timescale 1ns/100ps
module cecrx_initiator #(
  parameter int START_LO  = 121,
  parameter int START_PER = 147,
  parameter int ONE_LO    = 20,
  parameter int ZERO_LO   = 49,
  parameter int BIT_PER   = 79,
  parameter int DECIDE    = 34
) (
  input  wire logic fs_i,
  input  wire logic line_i,
  output logic      oe_o
);
  logic acked;
  initial begin
    oe_o  = 1'b0;
    acked = 1'b0;
  end
  // ==========================================================
  // Bit shaping
  // Low for lo samples, next fall after per samples; the line is sampled at the
  // decision point so the ACK answer of the follower can be seen
  task automatic pulse(input int lo, input int per);
    for (int i = 0; i < per; i++) begin
      @(posedge fs_i);
      oe_o <= (i < lo);
      if (i == DECIDE) begin
        acked = ~line_i;
      end
    end
  endtask
  task automatic send_start();
    pulse(START_LO, START_PER);
  endtask
  // Data is sent MSB first; the ACK bit goes out as a one that a follower may stretch
  task automatic send_block(input logic [7:0] d, input logic eom);
    for (int k = 7; k >= 0; k--) begin
      pulse(d[k] ? ONE_LO : ZERO_LO, BIT_PER);
    end
    pulse(eom ? ONE_LO : ZERO_LO, BIT_PER);
    pulse(ONE_LO, BIT_PER);
  endtask
  task automatic wait_fs(input int n);
    repeat (n) @(posedge fs_i);
  endtask
endmodule

// ===== test_cec_receiver_timing_checker.sv
// Self-checking bench for the CEC receiver timing checker
`timescale 1ns/100ps
`include "cecrx_consts.svh"
module test_cec_receiver_timing_checker;
  import cecrx_pkg::*;
  logic          clk_i;
  logic          rst_i;
  logic          fs_i;
  logic          tx_active_i;
  logic          cec_oe_o;
  logic          node_oe;
  logic          line;
  cecrx_wb_req_s req;
  cecrx_wb_rsp_s rsp;
  int            n_mismatch;
  int            checks;
  int            fs_cnt;
  int            oe_cnt;
  int            base;
  logic [31:0]   rdq;
  // Open-drain line with a pull-up
  assign line = ~(cec_oe_o | node_oe);
  cecrx_timing_checker dut (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .fs_i        (fs_i),
    .cec_i       (line),
    .tx_active_i (tx_active_i),
    .wb_req_i    (req),
    .wb_rsp_o    (rsp),
    .cec_o       (),
    .cec_oe_o    (cec_oe_o)
  );
  cecrx_initiator node (
    .fs_i   (fs_i),
    .line_i (line),
    .oe_o   (node_oe)
  );
  // ==========================================================
  // Clock, shortened sampling clock and drive counter
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Sampling clock runs at one tenth of the system clock to keep runs short
  always @(posedge clk_i) begin
    fs_cnt <= (fs_cnt == 9) ? 0 : fs_cnt + 1;
    fs_i   <= (fs_cnt < 5);
    if (cec_oe_o === 1'b1) begin
      oe_cnt <= oe_cnt + 1;
    end
  end
  // ==========================================================
  // Checking and bus tasks
  task automatic conclude();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int i;
    q = 32'h0000_0000;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (rsp.ack === 1'b1) begin
        break;
      end
    end
    if (i == 20) begin
      n_mismatch++;
      conclude();
    end else begin
      q = rsp.dat;
      req <= '0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, 4'hf, q);
    check(q & m, e);
  endtask
  task automatic ack_len(input int lo, input int hi);
    check(32'(oe_cnt - base >= lo && oe_cnt - base <= hi), 32'h0000_0001);
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    rst_i       = 1'b1;
    fs_i        = 1'b0;
    fs_cnt      = 0;
    oe_cnt      = 0;
    tx_active_i = 1'b0;
    req         = '0;
    n_mismatch  = 0;
    checks      = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`CECRX_ADR_CTRL, 32'hffff_ffff, `CECRX_CTRL_RST);
    rd(`CECRX_ADR_CFG, 32'hffff_ffff, `CECRX_CFG_RST);
    rd(`CECRX_ADR_SBIT, 32'hffff_ffff, `CECRX_SBIT_RST);
    rd(`CECRX_ADR_WAVE, 32'hffff_ffff, `CECRX_WAVE_RST);
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, 32'hffff_ffff, 32'h0000_0000);
    rd(`CECRX_ADR_STAT, 32'h0000_0600, 32'h0000_0000);
    // Low-level filter kept equal to the transmitter's data-rise setting
    wr(`CECRX_ADR_CFG, `CECRX_CFG_RST);
    wr(`CECRX_ADR_LADDR, 32'h0000_0010);
    wr(`CECRX_ADR_CTRL, 32'h0000_0001);
    node.wait_fs(10);
    // Matching header then data block, both answered
    base = oe_cnt;
    node.send_start();
    node.send_block(8'h04, 1'b0);
    check(32'(node.acked), 32'h0000_0001);
    ack_len(480, 520);
    rd(`CECRX_ADR_RBUF, 32'h0000_07ff, 32'h0000_0404);
    node.send_block(8'ha5, 1'b1);
    check(32'(node.acked), 32'h0000_0001);
    rd(`CECRX_ADR_RBUF, 32'h0000_07ff, 32'h0000_05a5);
    rd(`CECRX_ADR_STAT, 32'h0000_003f, 32'h0000_0003);
    wr(`CECRX_ADR_STAT, 32'h0000_003f);
    // ACK disabled: header still answered, data block left alone
    wr(`CECRX_ADR_CTRL, 32'h0000_0003);
    node.wait_fs(10);
    node.send_start();
    node.send_block(8'h04, 1'b0);
    check(32'(node.acked), 32'h0000_0001);
    rd(`CECRX_ADR_RBUF, 32'h0000_07ff, 32'h0000_0404);
    node.send_block(8'h11, 1'b1);
    check(32'(node.acked), 32'h0000_0000);
    rd(`CECRX_ADR_RBUF, 32'h0000_07ff, 32'h0000_0711);
    // Foreign header is not answered without other-address mode
    wr(`CECRX_ADR_CTRL, 32'h0000_0001);
    node.wait_fs(10);
    node.send_start();
    node.send_block(8'h05, 1'b1);
    check(32'(node.acked), 32'h0000_0000);
    // Short bit cycle: the fall at 50 periods is too early
    wr(`CECRX_ADR_STAT, 32'h0000_003f);
    node.wait_fs(10);
    base = oe_cnt;
    node.send_start();
    node.pulse(20, 50);
    node.pulse(20, 79);
    node.wait_fs(200);
    ack_len(1170, 1210);
    rd(`CECRX_ADR_STAT, 32'h0000_000c, 32'h0000_0004);
    // Bits stop: maximum error, partial data dropped
    wr(`CECRX_ADR_STAT, 32'h0000_003f);
    node.send_start();
    node.pulse(20, 79);
    node.wait_fs(120);
    rd(`CECRX_ADR_STAT, 32'h0000_010c, 32'h0000_0008);
    rd(`CECRX_ADR_RBUF, 32'h0000_0400, 32'h0000_0000);
    // Suspended maximum error is held until the timeout
    wr(`CECRX_ADR_CTRL, 32'h0000_0009);
    wr(`CECRX_ADR_STAT, 32'h0000_003f);
    node.send_start();
    node.pulse(20, 79);
    node.wait_fs(60);
    rd(`CECRX_ADR_STAT, 32'h0000_0008, 32'h0000_0000);
    node.wait_fs(100);
    rd(`CECRX_ADR_STAT, 32'h0000_0008, 32'h0000_0008);
    // Status clear honours lane 0 only
    wb(1'b1, `CECRX_ADR_STAT, 32'h0000_003f, 4'he, rdq);
    rd(`CECRX_ADR_STAT, 32'h0000_0008, 32'h0000_0008);
    wr(`CECRX_ADR_STAT, 32'h0000_003f);
    // Early data-bit rise with waveform checking on; stop before reconfiguring
    wr(`CECRX_ADR_CTRL, 32'h0000_0000);
    rd(`CECRX_ADR_STAT, 32'h0000_0600, 32'h0000_0000);
    wr(`CECRX_ADR_CTRL, 32'h0000_0011);
    node.send_start();
    node.pulse(10, 79);
    rd(`CECRX_ADR_STAT, 32'h0000_0130, 32'h0000_0020);
    wr(`CECRX_ADR_STAT, 32'h0000_003f);
    // Transmitter busy: reception held off
    tx_active_i <= 1'b1;
    rd(`CECRX_ADR_STAT, 32'h0000_0600, 32'h0000_0600);
    node.send_start();
    node.pulse(20, 79);
    rd(`CECRX_ADR_STAT, 32'h0000_0101, 32'h0000_0000);
    tx_active_i <= 1'b0;
    conclude();
  end
endmodule
